// File: fcs_defines.vh
`ifndef FCS_DEFINES_VH
`define FCS_DEFINES_VH

// flash command bytes
`define FCS_CMD_READ_ARRAY 8'hff
`define FCS_CMD_READ_ID 8'h90
`define FCS_CMD_READ_STATUS 8'h70
`define FCS_CMD_CLEAR_STATUS 8'h50
`define FCS_CMD_PROGRAM 8'h40
`define FCS_CMD_ERASE 8'h20
`define FCS_CMD_CONFIRM 8'hd0
`define FCS_CMD_SUSPEND 8'hb0

// operations started through the control register
`define FCS_OP_ARRAY 4'h0
`define FCS_OP_IDENT 4'h1
`define FCS_OP_STATUS 4'h2
`define FCS_OP_CLEAR 4'h3
`define FCS_OP_PROGRAM 4'h4
`define FCS_OP_ERASE 4'h5
`define FCS_OP_SUSPEND 4'h6
`define FCS_OP_RESUME 4'h7
`define FCS_OP_READ 4'h8

// step kinds of a sequence
`define FCS_K_WR 2'h0
`define FCS_K_RD 2'h1
`define FCS_K_POLL 2'h2
`define FCS_K_END 2'h3

// destinations of a read step
`define FCS_D_LO 2'h0
`define FCS_D_HI 2'h1
`define FCS_D_STAT 2'h2

// register indices (byte address = 4 * index)
`define FCS_REG_CTRL 3'h0
`define FCS_REG_ADDR 3'h1
`define FCS_REG_WDATA 3'h2
`define FCS_REG_RESULT 3'h3
`define FCS_REG_STATUS 3'h4
`define FCS_REG_PINS 3'h5
`define FCS_REG_LAST 3'h5

// field positions
`define FCS_CTRL_OP 3:0
`define FCS_CTRL_CLEAN 4
`define FCS_ST_BUSY 8
`define FCS_ST_UPPER_BAD 9
`define FCS_ST_REFUSED 10
`define FCS_READY_BIT 7
`define FCS_AXI_OKAY 2'h0
`define FCS_AXI_SLVERR 2'h2

// timing, ns and derived cycle counts at 125 MHz
`define FCS_CLK_NS 8
`define FCS_T_WP_NS 70
`define FCS_T_WH_NS 30
`define FCS_T_ACC_NS 90
`define FCS_T_REC_NS 30
`define FCS_SYNC_CYC 2
`define FCS_T_WP_CYC ((`FCS_T_WP_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_T_WH_CYC ((`FCS_T_WH_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_T_ACC_CYC ((`FCS_T_ACC_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS + `FCS_SYNC_CYC)
`define FCS_T_REC_CYC ((`FCS_T_REC_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)

`endif

// File: fcs_sync.v
`timescale 1ns/10ps
// two-stage synchroniser for pin inputs
module fcs_sync #(
  parameter W = 16
) (
  input wire clk,
  input wire reset,
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] stage1;
  always @(posedge clk) begin
    if (reset) begin
      stage1 <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule // fcs_sync

// File: fcs_axil_slave.v
`timescale 1ns/10ps
`include "fcs_defines.vh"
module fcs_axil_slave (
  input wire clk,
  input wire reset,
  input wire [7:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [7:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  output reg regWrEn,
  output reg [2:0] regWrIndex,
  output reg [31:0] regWrData,
  output reg [3:0] regWrStrb,
  output wire [2:0] rdIndex,
  input wire [31:0] rdData
);
  reg awHeld;
  reg wHeld;
  reg [7:0] awAddrQ;
  wire awTake = awready & awvalid;
  wire wTake = wready & wvalid;
  wire wrFire = awHeld & wHeld & ~bvalid;
  wire arTake = arready & arvalid;
  wire wrMapped = (awAddrQ[7:5] == 3'h0) && (awAddrQ[4:2] <= `FCS_REG_LAST);
  wire rdMapped = (araddr[7:5] == 3'h0) && (araddr[4:2] <= `FCS_REG_LAST);
  assign rdIndex = araddr[4:2];

  always @(posedge clk) begin
    if (reset) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `FCS_AXI_OKAY;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrQ <= 8'h00;
      regWrEn <= 1'b0;
      regWrIndex <= 3'h0;
      regWrData <= 32'h00000000;
      regWrStrb <= 4'h0;
    end else begin
      regWrEn <= 1'b0;
      awready <= ~((awHeld & ~wrFire) | awTake);
      wready <= ~((wHeld & ~wrFire) | wTake);
      if (bvalid && bready)
        bvalid <= 1'b0;
      if (awTake) begin
        awHeld <= 1'b1;
        awAddrQ <= awaddr;
      end
      if (wTake) begin
        wHeld <= 1'b1;
        regWrData <= wdata;
        regWrStrb <= wstrb;
      end
      if (wrFire) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wrMapped ? `FCS_AXI_OKAY : `FCS_AXI_SLVERR;
        regWrEn <= wrMapped;
        regWrIndex <= awAddrQ[4:2];
      end
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `FCS_AXI_OKAY;
    end else begin
      arready <= ~(arTake | (rvalid & ~rready));
      if (rvalid && rready)
        rvalid <= 1'b0;
      if (arTake) begin
        rvalid <= 1'b1;
        rdata <= rdMapped ? rdData : 32'h00000000;
        rresp <= rdMapped ? `FCS_AXI_OKAY : `FCS_AXI_SLVERR;
      end
    end
  end
endmodule // fcs_axil_slave

// File: fcs_flash_host.v
`timescale 1ns/10ps
`include "fcs_defines.vh"
// Functional notes
// RULE1 - 90H then reads at addresses 0, 1
// RULE2 - FFH returns device to array reads
// RULE3 - after 70H every read gives status
// RULE4 - status on low byte, upper byte zero
// RULE5 - status snapshot taken at read start
// RULE6 - toggle chip-select and output-enable each poll
// RULE7 - error bits stay until 50H clears
// RULE8 - program: 40H then address and data
// RULE9 - programming only turns ones into zeros
// RULE10 - ready bit zero while programming
// RULE11 - program, supply, lock error bits set
// RULE12 - B0H suspends program, ready plus suspended
// RULE13 - limited commands while program suspended
// RULE14 - D0H resumes, status reads follow
// RULE15 - erase: 20H then D0H at block
// RULE16 - erase self-timed, ready bit zero
// RULE17 - erase error, supply error on bad supply
// RULE18 - B0H pauses erase, status shows it
// RULE19 - limited commands while erase suspended
// RULE20 - chip-select high gives erase pseudo-standby
// RULE21 - clear status, read array after operations
// RULE22 - bad confirm sets both error bits
// RULE23 - status mode entered when operation starts
// RULE24 - erase suspend sets ready and suspended
// RULE25 - invalid command leaves operation unaffected
module fcs_flash_host (
  input wire clk,
  input wire reset,
  input wire [7:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output wire [1:0] bresp,
  output wire bvalid,
  input wire bready,
  input wire [7:0] araddr,
  input wire arvalid,
  output wire arready,
  output wire [31:0] rdata,
  output wire [1:0] rresp,
  output wire rvalid,
  input wire rready,
  output reg [21:0] flashAddr,
  output reg flashCeN,
  output reg flashOeN,
  output reg flashWeN,
  output reg [15:0] flashDqOut,
  output reg flashDqOeN,
  input wire [15:0] flashDqIn,
  output reg deep_reset_n
);
  localparam integer T_WP_I = `FCS_T_WP_CYC;
  localparam integer T_WH_I = `FCS_T_WH_CYC;
  localparam integer T_ACC_I = `FCS_T_ACC_CYC;
  localparam integer T_REC_I = `FCS_T_REC_CYC;
  localparam [7:0] T_WP = T_WP_I[7:0];
  localparam [7:0] T_WH = T_WH_I[7:0];
  localparam [7:0] T_ACC = T_ACC_I[7:0];
  localparam [7:0] T_REC = T_REC_I[7:0];
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_FETCH = 6'h02;
  localparam [5:0] ST_WLOW = 6'h04;
  localparam [5:0] ST_WHIGH = 6'h08;
  localparam [5:0] ST_RLOW = 6'h10;
  localparam [5:0] ST_GAP = 6'h20;

  wire regWrEn;
  wire [2:0] regWrIndex;
  wire [31:0] regWrData;
  wire [3:0] regWrStrb;
  wire [2:0] rdIndex;
  reg [31:0] rdData;
  wire [15:0] dqSync;

  reg [5:0] state;
  reg [7:0] cnt;
  reg [3:0] op;
  reg [2:0] step;
  reg busy;
  reg autoClean;
  reg [3:0] ctrlOp;
  reg [21:0] addrReg;
  reg [15:0] dataReg;
  reg [15:0] resultLo;
  reg [15:0] resultHi;
  reg [7:0] flashStatus;
  reg upperBad;
  reg refused;
  reg suspendPend;

  reg [1:0] kind;
  reg [21:0] stepAddr;
  reg [15:0] stepData;
  reg [1:0] stepDst;

  wire [31:0] strbMask = {{8{regWrStrb[3]}}, {8{regWrStrb[2]}}, {8{regWrStrb[1]}}, {8{regWrStrb[0]}}};
  wire ctrlWrite = regWrEn && (regWrIndex == `FCS_REG_CTRL) && regWrStrb[0];
  wire startReq = ctrlWrite && !busy;
  // a suspend order is taken while a program, erase or resume operation is busy
  wire suspendAsk = ctrlWrite && busy && (regWrData[`FCS_CTRL_OP] == `FCS_OP_SUSPEND) &&
    (op == `FCS_OP_PROGRAM || op == `FCS_OP_ERASE || op == `FCS_OP_RESUME);

  fcs_axil_slave i_fcs_axil_slave (
    .clk(clk),
    .reset(reset),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .regWrEn(regWrEn),
    .regWrIndex(regWrIndex),
    .regWrData(regWrData),
    .regWrStrb(regWrStrb),
    .rdIndex(rdIndex),
    .rdData(rdData)
  );

  fcs_sync #(
    .W(16)
  ) i_fcs_sync (
    .clk(clk),
    .reset(reset),
    .din(flashDqIn),
    .dout(dqSync)
  );

  always @* begin
    case (rdIndex)
      `FCS_REG_CTRL: rdData = {27'h0000000, autoClean, ctrlOp};
      `FCS_REG_ADDR: rdData = {10'h000, addrReg};
      `FCS_REG_WDATA: rdData = {16'h0000, dataReg};
      `FCS_REG_RESULT: rdData = {resultHi, resultLo};
      `FCS_REG_STATUS: rdData = {21'h000000, refused, upperBad, busy, flashStatus};
      `FCS_REG_PINS: rdData = {31'h00000000, deep_reset_n};
      default: rdData = 32'h00000000;
    endcase
  end

  // sequence table: one bus cycle per step, except a poll step, which repeats its read until ready
  always @* begin
    kind = `FCS_K_END;
    stepAddr = 22'h000000;
    stepData = 16'h0000;
    stepDst = `FCS_D_LO;
    case (op)
      `FCS_OP_ARRAY: begin
        if (step == 3'h0) begin
          kind = `FCS_K_WR;
          stepData = {8'h00, `FCS_CMD_READ_ARRAY}; // RULE2
        end
      end
      `FCS_OP_IDENT: begin
        case (step)
          3'h0: begin
            kind = `FCS_K_WR;
            stepData = {8'h00, `FCS_CMD_READ_ID}; // RULE1
          end
          3'h1: begin
            kind = `FCS_K_RD;
            stepAddr = 22'h000000; // RULE1
          end
          3'h2: begin
            kind = `FCS_K_RD;
            stepAddr = 22'h000001; // RULE1
            stepDst = `FCS_D_HI;
          end
          3'h3: begin
            kind = `FCS_K_WR;
            stepData = {8'h00, `FCS_CMD_READ_ARRAY}; // RULE2
          end
          default: kind = `FCS_K_END;
        endcase
      end
      `FCS_OP_STATUS: begin
        if (step == 3'h0) begin
          kind = `FCS_K_WR;
          stepData = {8'h00, `FCS_CMD_READ_STATUS}; // RULE3
        end else if (step == 3'h1) begin
          kind = `FCS_K_RD;
          stepDst = `FCS_D_STAT;
        end
      end
      `FCS_OP_CLEAR: begin
        if (step == 3'h0) begin
          kind = `FCS_K_WR;
          stepData = {8'h00, `FCS_CMD_CLEAR_STATUS}; // RULE7
        end
      end
      `FCS_OP_PROGRAM, `FCS_OP_ERASE, `FCS_OP_SUSPEND, `FCS_OP_RESUME: begin
        case (step)
          3'h0: begin
            kind = `FCS_K_WR;
            if (op == `FCS_OP_PROGRAM)
              stepData = {8'h00, `FCS_CMD_PROGRAM}; // RULE8
            else if (op == `FCS_OP_ERASE)
              stepData = {8'h00, `FCS_CMD_ERASE}; // RULE15
            else if (op == `FCS_OP_SUSPEND)
              stepData = {8'h00, `FCS_CMD_SUSPEND}; // RULE12 RULE18
            else
              stepData = {8'h00, `FCS_CMD_CONFIRM}; // RULE14
          end
          3'h1: begin
            // suspend and resume have no second write; they poll here
            kind = `FCS_K_WR;
            stepAddr = addrReg;
            if (op == `FCS_OP_PROGRAM)
              stepData = dataReg; // RULE8 RULE9
            else if (op == `FCS_OP_ERASE)
              stepData = {8'h00, `FCS_CMD_CONFIRM}; // RULE15
            else
              kind = `FCS_K_POLL; // RULE23
          end
          3'h2: begin
            if (op == `FCS_OP_PROGRAM || op == `FCS_OP_ERASE)
              kind = `FCS_K_POLL; // RULE23 RULE10 RULE16
            else if (autoClean && op == `FCS_OP_RESUME) begin
              kind = `FCS_K_WR;
              stepData = {8'h00, `FCS_CMD_CLEAR_STATUS}; // RULE21
            end
          end
          3'h3: begin
            if (autoClean && op != `FCS_OP_SUSPEND) begin
              kind = `FCS_K_WR;
              if (op == `FCS_OP_RESUME)
                stepData = {8'h00, `FCS_CMD_READ_ARRAY}; // RULE21
              else
                stepData = {8'h00, `FCS_CMD_CLEAR_STATUS}; // RULE21
            end
          end
          3'h4: begin
            if (autoClean && op != `FCS_OP_SUSPEND && op != `FCS_OP_RESUME) begin
              kind = `FCS_K_WR;
              stepData = {8'h00, `FCS_CMD_READ_ARRAY}; // RULE21
            end
          end
          default: kind = `FCS_K_END;
        endcase
      end
      `FCS_OP_READ: begin
        if (step == 3'h0) begin
          kind = `FCS_K_RD;
          stepAddr = addrReg;
        end
      end
      default: kind = `FCS_K_END;
    endcase
  end

  // software registers
  always @(posedge clk) begin
    if (reset) begin
      ctrlOp <= `FCS_OP_ARRAY;
      autoClean <= 1'b0;
      addrReg <= 22'h000000;
      dataReg <= 16'h0000;
      deep_reset_n <= 1'b1;
      refused <= 1'b0;
    end else begin
      if (startReq || suspendAsk) begin
        ctrlOp <= regWrData[`FCS_CTRL_OP];
        autoClean <= regWrData[`FCS_CTRL_CLEAN];
      end
      if (ctrlWrite && busy && !suspendAsk)
        refused <= 1'b1;
      else if (regWrEn && regWrIndex == `FCS_REG_STATUS && regWrStrb[1] && regWrData[`FCS_ST_REFUSED])
        refused <= 1'b0;
      if (regWrEn && !busy && regWrIndex == `FCS_REG_ADDR)
        addrReg <= (addrReg & ~strbMask[21:0]) | (regWrData[21:0] & strbMask[21:0]);
      if (regWrEn && !busy && regWrIndex == `FCS_REG_WDATA)
        dataReg <= (dataReg & ~strbMask[15:0]) | (regWrData[15:0] & strbMask[15:0]);
      if (regWrEn && regWrIndex == `FCS_REG_PINS && regWrStrb[0])
        deep_reset_n <= regWrData[0];
    end
  end

  // bus cycle engine; chip-select idles high between cycles
  always @(posedge clk) begin
    if (reset) begin
      state <= ST_IDLE;
      cnt <= 8'h00;
      op <= `FCS_OP_ARRAY;
      step <= 3'h0;
      busy <= 1'b0;
      flashAddr <= 22'h000000;
      flashCeN <= 1'b1; // RULE20
      flashOeN <= 1'b1;
      flashWeN <= 1'b1;
      flashDqOut <= 16'h0000;
      flashDqOeN <= 1'b1;
      resultLo <= 16'h0000;
      resultHi <= 16'h0000;
      flashStatus <= 8'h00;
      upperBad <= 1'b0;
      suspendPend <= 1'b0;
    end else begin
      if (suspendAsk)
        suspendPend <= 1'b1;
      case (state)
        ST_IDLE: begin
          if (startReq) begin
            op <= regWrData[`FCS_CTRL_OP];
            step <= 3'h0;
            busy <= 1'b1;
            upperBad <= 1'b0;
            state <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          flashAddr <= stepAddr;
          if (suspendPend && kind == `FCS_K_POLL) begin
            // swap the running poll for a suspend sequence
            op <= `FCS_OP_SUSPEND; // RULE12 RULE18
            step <= 3'h0;
            suspendPend <= 1'b0;
          end else if (kind == `FCS_K_WR) begin
            flashDqOut <= stepData;
            flashDqOeN <= 1'b0;
            flashCeN <= 1'b0;
            flashWeN <= 1'b0;
            cnt <= T_WP - 8'h01;
            state <= ST_WLOW;
          end else if (kind == `FCS_K_END) begin
            busy <= 1'b0;
            suspendPend <= 1'b0;
            state <= ST_IDLE;
          end else begin
            flashDqOeN <= 1'b1;
            flashCeN <= 1'b0; // RULE5 RULE6
            flashOeN <= 1'b0; // RULE5 RULE6
            cnt <= T_ACC - 8'h01;
            state <= ST_RLOW;
          end
        end
        ST_WLOW: begin
          if (cnt == 8'h00) begin
            flashWeN <= 1'b1;
            cnt <= T_WH - 8'h01;
            state <= ST_WHIGH;
          end else
            cnt <= cnt - 8'h01;
        end
        ST_WHIGH: begin
          if (cnt == 8'h00) begin
            flashCeN <= 1'b1;
            flashDqOeN <= 1'b1;
            step <= step + 3'h1;
            cnt <= T_REC - 8'h01;
            state <= ST_GAP;
          end else
            cnt <= cnt - 8'h01;
        end
        ST_RLOW: begin
          if (cnt == 8'h00) begin
            flashCeN <= 1'b1; // RULE6
            flashOeN <= 1'b1; // RULE6
            if (kind == `FCS_K_POLL || stepDst == `FCS_D_STAT) begin
              flashStatus <= dqSync[7:0]; // RULE7 RULE11 RULE17 RULE22 RULE24
              upperBad <= upperBad | (dqSync[15:8] != 8'h00); // RULE4
            end else if (stepDst == `FCS_D_HI)
              resultHi <= dqSync;
            else
              resultLo <= dqSync;
            // poll again with a fresh falling edge until ready
            if (!(kind == `FCS_K_POLL && !dqSync[`FCS_READY_BIT])) // RULE10 RULE12 RULE16
              step <= step + 3'h1;
            cnt <= T_REC - 8'h01;
            state <= ST_GAP;
          end else
            cnt <= cnt - 8'h01;
        end
        ST_GAP: begin
          if (cnt == 8'h00)
            state <= ST_FETCH;
          else
            cnt <= cnt - 8'h01;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // fcs_flash_host

// File: fcs_flash_host_chk.sv
`timescale 1ns/10ps
module fcs_flash_host_chk (
  input wire clk,
  input wire reset,
  input wire bvalid,
  input wire bready,
  input wire rvalid,
  input wire rready,
  input wire [21:0] flashAddr,
  input wire flashCeN,
  input wire flashOeN,
  input wire flashWeN,
  input wire [15:0] flashDqOut,
  input wire flashDqOeN
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  b_hold_a: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped early");
  r_hold_a: assert property (rvalid && !rready |=> rvalid)
    else $error("read data dropped early");
  we_pulse_a: assert property ($fell(flashWeN) |-> ##8 !flashWeN ##1 flashWeN)
    else $error("write pulse not nine cycles");
  we_hold_a: assert property (!flashWeN |-> !flashDqOeN && !flashCeN &&
    ($fell(flashWeN) || $stable(flashAddr) && $stable(flashDqOut)))
    else $error("write cycle not held");
  ce_tail_a: assert property ($rose(flashWeN) |-> !flashCeN [*4] ##1 flashCeN)
    else $error("chip select tail wrong");
  rd_fresh_a: assert property ($fell(flashOeN) |-> $fell(flashCeN) && flashWeN)
    else $error("read without fresh select");
  rd_len_a: assert property ($fell(flashOeN) |-> ##13 !flashOeN ##1 (flashOeN && flashCeN))
    else $error("read cycle length wrong");
  rd_release_a: assert property (!flashOeN |-> flashDqOeN && ($fell(flashOeN) || $stable(flashAddr)))
    else $error("read cycle drives data or moves address");
  bus_clash_a: assert property (flashWeN || flashOeN)
    else $error("write and output enable both low");

  cover property ($rose(flashWeN));
  cover property ($fell(flashOeN));
  cover property (bvalid && bready);
endmodule // fcs_flash_host_chk

bind fcs_flash_host fcs_flash_host_chk i_fcs_flash_host_chk (.clk(clk), .reset(reset), .bvalid(bvalid),
  .bready(bready), .rvalid(rvalid), .rready(rready), .flashAddr(flashAddr), .flashCeN(flashCeN),
  .flashOeN(flashOeN), .flashWeN(flashWeN), .flashDqOut(flashDqOut), .flashDqOeN(flashDqOeN));

// File: fcs_flash_model.sv
`timescale 1ns/10ps
module fcs_flash_model #(
  parameter [15:0] MFR_ID = 16'h00a1, // arbitrary value
  parameter [15:0] DEV_ID = 16'h5c3e, // arbitrary value
  parameter integer OP_CYC = 300
) (
  input wire clk,
  input wire [21:0] addr,
  input wire ceN,
  input wire oeN,
  input wire weN,
  input wire [15:0] dIn,
  input wire rstN,
  input wire vppLow,
  output wire [15:0] dOut
);
  logic [15:0] mem [0:255];
  logic [1:0] mode, setup;
  logic [3:0] err;
  logic pSusp, eSusp, sReq, pWe, pRd;
  logic [15:0] pCnt, eCnt, pData, last;
  logic [7:0] pAddr, snap;
  logic [3:0] eBlk;
  wire pRun = pCnt != 0 && !pSusp;
  wire eRun = eCnt != 0 && !eSusp;
  wire [7:0] stat = {!(pRun || eRun), eSusp, err[3:1], pSusp, err[0], 1'b0};
  wire rd = !ceN && !oeN && rstN;
  // released bus shows the inverse of the last value
  assign dOut = !rd ? ~last : mode == 2'h2 ? {8'h00, snap} :
    mode == 2'h1 ? (addr[0] ? DEV_ID : MFR_ID) : mem[addr[7:0]];
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 16'hffff;
    {mode, setup, err, pSusp, eSusp, sReq, pRd, pCnt, eCnt, last, snap} = '0;
    pWe = 1'b1;
  end
  always @(posedge clk) begin
    pWe <= weN;
    pRd <= rd;
    if (rd) last <= dOut;
    if (rd && !pRd) snap <= stat;
    if (!rstN) begin
      mode <= 2'h0;
      setup <= 2'h0;
    end else if (weN && !pWe && !ceN) begin
      setup <= 2'h0;
      if (setup == 2'h1) begin
        mode <= 2'h2;
        if (vppLow) err[1] <= 1'b1;
        else begin
          pAddr <= addr[7:0];
          pData <= dIn;
          pCnt <= OP_CYC;
        end
      end else if (setup == 2'h2) begin
        mode <= 2'h2;
        if (dIn[7:0] != 8'hd0) err[3:2] <= 2'h3;
        else if (vppLow) err[3:1] <= 3'h5;
        else begin
          eBlk <= addr[7:4];
          eCnt <= OP_CYC;
          for (int i = 0; i < 16; i++) mem[{addr[7:4], i[3:0]}] <= 16'h0000;
        end
      end else if (pRun || eRun) begin
        if (dIn[7:0] == 8'h70) mode <= 2'h2;
        if (dIn[7:0] == 8'hb0) sReq <= 1'b1;
      end else case (dIn[7:0])
        8'hff: mode <= 2'h0;
        8'h90: mode <= 2'h1;
        8'h70: mode <= 2'h2;
        8'h50: err <= 4'h0;
        8'h40, 8'h10: if (!pSusp) setup <= 2'h1;
        8'h20: if (!pSusp && !eSusp) setup <= 2'h2;
        8'hd0: if (pSusp || eSusp) begin
          mode <= 2'h2;
          if (pSusp) pSusp <= 1'b0;
          else eSusp <= 1'b0;
        end
        default: ;
      endcase
    end
    if (pRun) begin
      if (sReq) begin
        pSusp <= 1'b1;
        sReq <= 1'b0;
      end else begin
        pCnt <= pCnt - 1;
        if (pCnt == 1) mem[pAddr] <= mem[pAddr] & pData;
      end
    end else if (eRun) begin
      if (sReq) begin
        eSusp <= 1'b1;
        sReq <= 1'b0;
      end else begin
        eCnt <= eCnt - 1;
        if (eCnt == 1) for (int i = 0; i < 16; i++) mem[{eBlk, i[3:0]}] <= 16'hffff;
      end
    end
  end
endmodule // fcs_flash_model

// File: fcs_flash_host_bench.sv
`timescale 1ns/10ps
module fcs_flash_host_bench;
  localparam [15:0] MFR = 16'h00a1; // arbitrary value
  localparam [15:0] DEV = 16'h5c3e; // arbitrary value
  logic clk, reset, awvalid, wvalid, bready, arvalid, rready, vppLow;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rd;
  logic [3:0] wstrb;
  logic [1:0] rr;
  wire awready, wready, bvalid, arready, rvalid, flashCeN, flashOeN, flashWeN, flashDqOeN, deep_reset_n;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [21:0] flashAddr;
  wire [15:0] flashDqOut, devOut;
  wire [15:0] dq = !flashDqOeN ? flashDqOut : devOut;
  int fails, compares;

  fcs_flash_host i_fcs_flash_host (.clk(clk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .flashAddr(flashAddr),
    .flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN), .flashDqOut(flashDqOut),
    .flashDqOeN(flashDqOeN), .flashDqIn(dq), .deep_reset_n(deep_reset_n));
  fcs_flash_model #(.MFR_ID(MFR), .DEV_ID(DEV)) i_fcs_flash_model (.clk(clk), .addr(flashAddr),
    .ceN(flashCeN), .oeN(flashOeN), .weN(flashWeN), .dIn(dq), .rstN(deep_reset_n), .vppLow(vppLow),
    .dOut(devOut));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rr = bresp;
    bready <= 1'b0;
  endtask
  task automatic rdReg(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask
  // start an operation and poll until busy clears
  task automatic op(input logic [4:0] o);
    wr(8'h00, {27'h0, o}, 4'h1);
    do rdReg(8'h10); while (rd[8] !== 1'b0);
  endtask
  task automatic stat(input string n, input logic [31:0] e);
    rdReg(8'h10);
    check(n, e, rd & 32'h7ff);
  endtask
  task automatic rdArr(input string n, input logic [21:0] a, input logic [15:0] e);
    wr(8'h04, {10'h0, a}, 4'hf);
    op(5'h8);
    rdReg(8'h0c);
    check(n, {16'h0, e}, {16'h0, rd[15:0]});
  endtask
  task automatic prog(input logic [21:0] a, input logic [15:0] d, input logic [4:0] o);
    wr(8'h04, {10'h0, a}, 4'hf);
    wr(8'h08, {16'h0, d}, 4'h3);
    op(o);
  endtask
  task automatic summarize;
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    summarize();
  end
  initial begin
    {reset, awvalid, wvalid, bready, arvalid, rready, vppLow} = 7'h40;
    {awaddr, araddr, wdata, wstrb} = '0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    stat("status after reset", 32'h0);
    rdReg(8'h18);
    check("unmapped rresp", 32'h2, {30'h0, rr});
    check("unmapped rdata", 32'h0, rd);
    wr(8'h18, 32'h1, 4'hf);
    check("unmapped bresp", 32'h2, {30'h0, rr});
    wr(8'h14, 32'h0, 4'hf);
    check("pins bresp", 32'h0, {30'h0, rr});
    rdReg(8'h14);
    check("deep reset pin", 32'h0, {31'h0, deep_reset_n});
    check("pins readback", 32'h0, rd);
    wr(8'h14, 32'h1, 4'hf);
    op(5'h1);
    rdReg(8'h0c);
    check("identifier", {DEV, MFR}, rd);
    rdArr("array after ident", 22'h5, 16'hffff);
    prog(22'h12, 16'ha5f0, 5'h4);
    stat("program status", 32'h80);
    rdArr("status mode read", 22'h33, 16'h0080);
    op(5'h0);
    rdArr("programmed word", 22'h12, 16'ha5f0);
    prog(22'h12, 16'h0ff0, 5'h14);
    stat("ones kept no error", 32'h80);
    rdArr("and of words", 22'h12, 16'h05f0);
    vppLow <= 1'b1;
    prog(22'h40, 16'h0000, 5'h4);
    stat("supply program", 32'h88);
    op(5'h5);
    stat("supply erase", 32'ha8);
    op(5'h2);
    stat("errors sticky", 32'ha8);
    op(5'h3);
    op(5'h2);
    stat("errors cleared", 32'h80);
    vppLow <= 1'b0;
    for (int o = 6; o < 8; o++) begin
      op(o[4:0]);
      stat("idle suspend resume", 32'h80);
    end
    prog(22'h22, 16'h1234, 5'h14);
    wr(8'h04, 32'h10, 4'hf);
    op(5'h15);
    stat("erase status", 32'h80);
    rdArr("erased word", 22'h12, 16'hffff);
    rdArr("other block kept", 22'h22, 16'h1234);
    wr(8'h04, 32'h30, 4'hf);
    wr(8'h08, 32'hff, 4'h3);
    wr(8'h00, 32'h4, 4'h1);
    op(5'h6);
    stat("program suspended", 32'h84);
    op(5'h0);
    rdArr("read in suspend", 22'h22, 16'h1234);
    op(5'h17);
    stat("program resumed", 32'h80);
    rdArr("resumed word", 22'h30, 16'h00ff);
    wr(8'h04, 32'h20, 4'hf);
    wr(8'h00, 32'h5, 4'h1);
    op(5'h6);
    stat("erase suspended", 32'hc0);
    prog(22'h60, 16'h0f0f, 5'h4);
    stat("program in erase suspend", 32'hc0);
    op(5'h17);
    stat("erase resumed", 32'h80);
    rdArr("resumed erase", 22'h22, 16'hffff);
    rdArr("word in suspend", 22'h60, 16'h0f0f);
    wr(8'h04, 32'h40, 4'hf);
    wr(8'h00, 32'h15, 4'h1);
    wr(8'h00, 32'h2, 4'h1);
    wr(8'h04, 32'h3, 4'hf);
    rdReg(8'h10);
    check("refused while busy", 32'h500, rd & 32'h700);
    do rdReg(8'h10); while (rd[8] !== 1'b0);
    wr(8'h10, 32'h400, 4'h2);
    stat("refused cleared", 32'h80);
    rdReg(8'h00);
    check("ctrl kept", 32'h15, rd);
    rdReg(8'h04);
    check("addr kept", 32'h40, rd);
    summarize();
  end
endmodule // fcs_flash_host_bench
